// File: rtl/rfcw_device.sv
// Operation
// - narrow mode: 12-bit denominator, upper bits ignored
// - wide mode: upper ten above lower twelve
// - host zeroes upper bits below 4096
// - timeout 0..3: pin float, -, low, high
// - timeout 1: manual fast-lock, pin low
// - timeout 4..16383: timed fast-lock on pin
// - fast-lock lasts twice timeout comparison cycles
// - pump current code k gives k+1
// - cycle-slip codes divide rate 1,2,4,16
// - quarter-rate divides RF lock-detect ticks
// - host sets quarter-rate above 20 MHz
// - fast-lock word field layout
// - lock-detect reset word field layout
// - counter reset holds counters, floats pump
// - pump tri-state floats pump only
`timescale 1ns/1ps
`default_nettype none
module rfcw_device
	import rfcw_pkg::*;
(
	input wire logic core_clk, // comparison-side clock
	input wire logic rst_n, // async reset, active low
	rfcw_link_if.device link, // serial link from the host
	input wire logic pd_cycle, // one pulse per comparison cycle
	input wire logic freq_write, // pulse on each new frequency write
	input wire logic frac_wide_sel, // 1 = 22-bit denominator mode
	input wire logic [11:0] den_lower, // lower denominator bits
	output logic [21:0] rf_frac_denominator, // effective denominator
	output logic rf_fastlock_active, // fast-lock conditions forced
	output logic [4:0] rf_pump_mult, // pump current in base units
	output logic [2:0] csr_log2, // log2 of sample-rate reduction
	output logic rf_fastlock_pin_o, // fast-lock pin level
	output logic rf_fastlock_pin_oe, // fast-lock pin driven
	output logic rf_ld_tick, // comparison tick to RF lock detect
	output logic if_ld_tick, // comparison tick to IF lock detect
	output logic rf_counters_reset, // hold RF N and R counters
	output logic if_counters_reset, // hold IF N and R counters
	output logic rf_pump_hiz, // RF charge pump tri-stated
	output logic if_pump_hiz // IF charge pump tri-stated
);

	////////////////////////////////////////////////////////////////////////
	// link domain: shift in, hold on the latching edge
	logic [23:0] shift_q; // serial shift register
	logic [23:0] hold_q; // stable copy for the crossing
	logic word_tgl_q; // flips once per latched word

	// shift on edges with latch low; the edge with latch high captures
	always_ff @(posedge link.link_clk or negedge rst_n)
	begin
		if (!rst_n)
			shift_q <= 24'h000000;
		else if (!link.link_le)
			shift_q <= {shift_q[22:0], link.link_data};
	end

	// capture and announce; hold stays still until the next frame ends
	always_ff @(posedge link.link_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hold_q <= 24'h000000;
			word_tgl_q <= 1'b0;
		end
		else if (link.link_le)
		begin
			hold_q <= shift_q;
			word_tgl_q <= ~word_tgl_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// crossing: toggle through two flops, third for the edge
	logic tgl_s1_q; // first synchroniser stage
	logic tgl_s2_q; // second synchroniser stage
	logic tgl_s3_q; // previous synchronised value

	// a full frame of link edges passes before hold_q may change again
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end
		else
		begin
			tgl_s1_q <= word_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// word decode
	wire new_word = tgl_s2_q ^ tgl_s3_q; // one pulse per latched word
	wire [3:0] word_sel = hold_q[SEL_W-1:0]; // word-select bits
	wire wr_denom = new_word && (word_sel == SEL_DENOM);
	wire wr_fastlock = new_word && (word_sel == SEL_FASTLOCK);
	wire wr_ldrst = new_word && (word_sel == SEL_LDRST);

	logic [9:0] fd_hi_q; // upper denominator bits
	logic [13:0] toc_q; // fast-lock timeout
	logic [3:0] cpf_q; // fast-lock pump current code
	logic [1:0] csr_q; // cycle-slip reduction code
	logic qrate_q; // lock-detect quarter rate
	logic rf_tri_q; // RF pump tri-state
	logic if_tri_q; // IF pump tri-state
	logic rf_counter_reset_q; // RF counter reset
	logic if_rst_q; // IF counter reset
	logic powerup_q; // reset held since power-up

	// configuration registers, loaded from matching words only
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fd_hi_q <= 10'h000;
			toc_q <= TOC_HIZ;
			cpf_q <= 4'h0;
			csr_q <= 2'h0;
		end
		else
		begin
			if (wr_denom)
				fd_hi_q <= hold_q[FD_HI_LSB +: FD_HI_W];
			if (wr_fastlock)
			begin
				toc_q <= hold_q[TOC_LSB +: TOC_W];
				cpf_q <= hold_q[CPF_LSB +: CPF_W];
				csr_q <= hold_q[CSR_LSB +: CSR_W];
			end
		end
	end

	// reset word; power-up counter reset stands until the first such word
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			qrate_q <= 1'b0;
			rf_tri_q <= 1'b0;
			if_tri_q <= 1'b0;
			rf_counter_reset_q <= 1'b0;
			if_rst_q <= 1'b0;
			powerup_q <= 1'b1;
		end
		else if (wr_ldrst)
		begin
			qrate_q <= hold_q[QRATE_BIT];
			rf_tri_q <= hold_q[RF_TRI_BIT];
			if_tri_q <= hold_q[IF_TRI_BIT];
			rf_counter_reset_q <= hold_q[RF_COUNTER_RESET_BIT];
			if_rst_q <= hold_q[IF_RST_BIT];
			powerup_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fast-lock timer, counted in comparison cycles
	logic [14:0] fl_cnt_q; // remaining fast-lock cycles
	wire timed_mode = (toc_q >= TOC_TIMED_MIN);
	wire manual_mode = (toc_q == TOC_MANUAL);
	wire fl_running = timed_mode && (fl_cnt_q != 15'h0000);
	wire [14:0] fl_load = {toc_q, 1'b0};

	// restart on a frequency write; a mode change drops a running period
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			fl_cnt_q <= 15'h0000;
		else if (freq_write && timed_mode)
			fl_cnt_q <= fl_load;
		else if (!timed_mode)
			fl_cnt_q <= 15'h0000;
		else if (pd_cycle && fl_running)
			fl_cnt_q <= fl_cnt_q - 15'h0001;
	end

	////////////////////////////////////////////////////////////////////////
	// lock-detect tick divider
	logic [1:0] ld_div_q; // counts comparison cycles by four

	// free-running so the quarter-rate tick is evenly spaced
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ld_div_q <= 2'h0;
		else if (pd_cycle)
			ld_div_q <= ld_div_q + 2'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// output decode
	wire fl_active_d = manual_mode || fl_running;
	wire [21:0] den_d = frac_wide_sel ? {fd_hi_q, den_lower}
		: {10'h000, den_lower};
	wire [4:0] pump_d = fl_active_d ? ({1'b0, cpf_q} + 5'h01)
		: PUMP_MULT_STEADY;
	wire rf_tick_d = pd_cycle && (!qrate_q || (ld_div_q == QRATE_LAST));
	wire rf_creset_d = rf_counter_reset_q || powerup_q;
	wire if_creset_d = if_rst_q || powerup_q;
	wire rf_hiz_d = rf_creset_d || rf_tri_q;
	wire if_hiz_d = if_creset_d || if_tri_q;
	logic [2:0] csr_d; // reduction per code
	logic pin_o_d; // pin level
	logic pin_oe_d; // pin drive

	// cycle-slip code to divider
	always_comb
	begin
		unique case (csr_q)
			2'h0: csr_d = CSR_LOG2_C0;
			2'h1: csr_d = CSR_LOG2_C1;
			2'h2: csr_d = CSR_LOG2_C2;
			2'h3: csr_d = CSR_LOG2_C3;
		endcase
	end

	// pin function; timed mode drives low only while the period runs
	always_comb
	begin
		pin_o_d = 1'b0;
		pin_oe_d = 1'b0;
		if (toc_q == TOC_DRIVE_HIGH)
		begin
			pin_o_d = 1'b1;
			pin_oe_d = 1'b1;
		end
		else if ((toc_q == TOC_DRIVE_LOW) || manual_mode)
			pin_oe_d = 1'b1;
		else if (fl_running)
			pin_oe_d = 1'b1;
	end

	// every output leaves from a flop
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rf_frac_denominator <= 22'h000000;
			rf_fastlock_active <= 1'b0;
			rf_pump_mult <= PUMP_MULT_STEADY;
			csr_log2 <= CSR_LOG2_C0;
			rf_fastlock_pin_o <= 1'b0;
			rf_fastlock_pin_oe <= 1'b0;
			rf_ld_tick <= 1'b0;
			if_ld_tick <= 1'b0;
			rf_counters_reset <= 1'b1;
			if_counters_reset <= 1'b1;
			rf_pump_hiz <= 1'b1;
			if_pump_hiz <= 1'b1;
		end
		else
		begin
			rf_frac_denominator <= den_d;
			rf_fastlock_active <= fl_active_d;
			rf_pump_mult <= pump_d;
			csr_log2 <= csr_d;
			rf_fastlock_pin_o <= pin_o_d;
			rf_fastlock_pin_oe <= pin_oe_d;
			rf_ld_tick <= rf_tick_d;
			if_ld_tick <= pd_cycle; // IF path never divided
			rf_counters_reset <= rf_creset_d;
			if_counters_reset <= if_creset_d;
			rf_pump_hiz <= rf_hiz_d;
			if_pump_hiz <= if_hiz_d;
		end
	end

endmodule // rfcw_device
`default_nettype wire

// File: shared/rfcw_pkg.sv
`default_nettype none
package rfcw_pkg;

	////////////////////////////////////////////////////////////////////////
	// serial word layout
	localparam int WORD_W = 24; // bits per control word
	localparam int SEL_W = 4; // word-select field width, bits 3..0
	localparam logic [3:0] SEL_DENOM = 4'hB; // upper denominator word
	localparam logic [3:0] SEL_FASTLOCK = 4'hD; // fast-lock control word
	localparam logic [3:0] SEL_LDRST = 4'hF; // lock-detect and reset word

	// denominator word fields
	localparam int FD_LO_W = 12; // lower denominator bits
	localparam int FD_HI_W = 10; // upper denominator bits
	localparam int FD_W = 22; // full wide denominator
	localparam int FD_HI_LSB = 14; // position of upper bits in the word

	// fast-lock control word fields
	localparam int TOC_LSB = 4;
	localparam int TOC_W = 14;
	localparam int CPF_LSB = 18;
	localparam int CPF_W = 4;
	localparam int CSR_LSB = 22;
	localparam int CSR_W = 2;
	localparam int FLCNT_W = 15; // holds twice the largest timeout
	localparam logic [13:0] TOC_HIZ = 14'h0000; // pin floats
	localparam logic [13:0] TOC_MANUAL = 14'h0001; // forced fast-lock, pin low
	localparam logic [13:0] TOC_DRIVE_LOW = 14'h0002; // pin driven low
	localparam logic [13:0] TOC_DRIVE_HIGH = 14'h0003; // pin driven high
	localparam logic [13:0] TOC_TIMED_MIN = 14'h0004; // first timed value
	localparam int PUMP_MULT_W = 5; // 1x .. 16x
	localparam logic [4:0] PUMP_MULT_STEADY = 5'h01; // base unit outside fast-lock

	// cycle-slip reduction: log2 of the sample-rate divider per code
	localparam int CSR_LOG2_W = 3;
	localparam logic [2:0] CSR_LOG2_C0 = 3'h0; // 1
	localparam logic [2:0] CSR_LOG2_C1 = 3'h1; // 1/2
	localparam logic [2:0] CSR_LOG2_C2 = 3'h2; // 1/4
	localparam logic [2:0] CSR_LOG2_C3 = 3'h4; // 1/16

	// lock-detect and reset word fields
	localparam int RF_TRI_BIT = 4;
	localparam int IF_TRI_BIT = 5;
	localparam int RF_COUNTER_RESET_BIT = 6;
	localparam int IF_RST_BIT = 7;
	localparam int FIXED_ONE_BIT = 11;
	localparam int QRATE_BIT = 13;
	localparam logic [1:0] QRATE_LAST = 2'h3; // divide by 4

	////////////////////////////////////////////////////////////////////////
	// host register map (APB, one word each)
	localparam logic [11:0] ADDR_WORD = 12'h000; // write starts a frame
	localparam logic [11:0] ADDR_STATUS = 12'h004; // bit 0 busy
	localparam logic [11:0] ADDR_LAST = 12'h008; // last word sent
	localparam int STATUS_BUSY_BIT = 0;
	localparam logic [23:0] WORD_RESET = 24'h000000;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CORE_PERIOD_NS = 20;
	localparam int LINK_MIN_PERIOD_NS = 50; // link limited to 20 MHz
	localparam int LINK_HALF_CYC = (LINK_MIN_PERIOD_NS / 2 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int GAP_CYC = 8; // idle core cycles after each latch
	localparam int CNT_W = 4;
	localparam int EDGE_W = 5;
	localparam logic [4:0] LATCH_EDGE = 5'h18; // the 25th edge latches

	typedef enum logic [1:0]
	{
		RFCW_IDLE = 2'b00,
		RFCW_SHIFT = 2'b01,
		RFCW_GAP = 2'b10
	} rfcw_state_t;

endpackage
`default_nettype wire

// File: shared/rfcw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rfcw_link_if;
	logic link_clk; // serial clock, made by the host
	logic link_data; // serial data, msb first
	logic link_le; // latch enable, high on the latching edge

	modport host
	(
		output link_clk,
		output link_data,
		output link_le
	);

	modport device
	(
		input link_clk,
		input link_data,
		input link_le
	);
endinterface
`default_nettype wire

// File: rtl/rfcw_host.sv
`timescale 1ns/1ps
`default_nettype none
module rfcw_host
	import rfcw_pkg::*;
(
	input wire logic core_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	rfcw_link_if.host link // serial link to the device
);

	////////////////////////////////////////////////////////////////////////
	// APB decode
	rfcw_state_t state_q; // frame sequencer state
	logic [23:0] word_q; // word being sent
	logic link_clk_q; // link clock out
	logic link_data_q; // link data out
	logic link_le_q; // latch enable out
	wire busy = (state_q != RFCW_IDLE);
	wire access = psel && penable && !pready;
	wire hit_word = (paddr == ADDR_WORD);
	wire hit_status = (paddr == ADDR_STATUS);
	wire hit_last = (paddr == ADDR_LAST);
	wire unmapped = !(hit_word || hit_status || hit_last);
	wire bad_write = pwrite && !hit_word; // status and last are read-only
	wire stall = pwrite && hit_word && busy; // wait for the link to free up
	wire start = access && pwrite && hit_word && !busy;
	wire [31:0] rd_d = hit_status ? {31'h00000000, busy}
		: hit_last ? {8'h00, word_q} : 32'h00000000;

	// one wait state, longer for a word write while a frame is still running
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= access && !stall;
			pslverr <= access && !stall && (unmapped || bad_write);
			prdata <= (access && !pwrite) ? rd_d : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame sequencer; link clock divided from core clock
	logic [3:0] half_q; // cycles left in this half period
	logic [4:0] edge_q; // rising edges given so far
	wire half_done = (half_q == 4'h0);
	wire [3:0] half_load = CNT_W'(LINK_HALF_CYC - 1);

	// data changes on falling edges, device samples on rising ones
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= RFCW_IDLE;
			word_q <= WORD_RESET;
			half_q <= 4'h0;
			edge_q <= 5'h00;
			link_clk_q <= 1'b0;
			link_data_q <= 1'b0;
			link_le_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				RFCW_IDLE:
				begin
					if (start)
					begin
						word_q <= pwdata[23:0];
						link_data_q <= pwdata[23];
						half_q <= half_load;
						edge_q <= 5'h00;
						state_q <= RFCW_SHIFT;
					end
				end
				RFCW_SHIFT:
				begin
					if (!half_done)
						half_q <= half_q - 4'h1;
					else if (!link_clk_q)
					begin
						link_clk_q <= 1'b1;
						half_q <= half_load;
						edge_q <= edge_q + 5'h01;
					end
					else
					begin
						link_clk_q <= 1'b0;
						half_q <= half_load;
						// edge_q counts rises from one, so 24 data rises come before the latch
						if (edge_q == LATCH_EDGE + 5'h01)
						begin
							link_le_q <= 1'b0;
							half_q <= CNT_W'(GAP_CYC - 1);
							state_q <= RFCW_GAP;
						end
						else if (edge_q == LATCH_EDGE)
							link_le_q <= 1'b1;
						else
							link_data_q <= word_q[5'd23 - edge_q];
					end
				end
				RFCW_GAP:
				begin
					if (half_done)
						state_q <= RFCW_IDLE;
					else
						half_q <= half_q - 4'h1;
				end
				default:
					state_q <= RFCW_IDLE;
			endcase
		end
	end

	assign link.link_clk = link_clk_q;
	assign link.link_data = link_data_q;
	assign link.link_le = link_le_q;

endmodule // rfcw_host
`default_nettype wire

// File: testbench/rfcw_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rfcw_properties
(
	input wire logic core_clk, // host clock
	input wire logic rst_n, // async reset, active low
	input wire logic link_clk, // serial clock
	input wire logic link_data, // serial data
	input wire logic link_le // latch enable
);
	////////////////////////////////////////////////////////////////
	// helper: rising link edges seen in the current frame
	logic clk_prev_q; // link clock one core cycle ago
	logic [4:0] edge_cnt_q; // edges counted so far
	wire logic [4:0] edge_cnt_d;
	// cleared on the fall after the latching edge, where latch enable drops too
	assign edge_cnt_d = (clk_prev_q && !link_clk && edge_cnt_q == 5'h19) ? 5'h00 :
		(link_clk && !clk_prev_q) ? edge_cnt_q + 5'h01 : edge_cnt_q;
	// short register update only
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clk_prev_q <= 1'b0;
			edge_cnt_q <= 5'h00;
		end
		else
		begin
			clk_prev_q <= link_clk;
			edge_cnt_q <= edge_cnt_d;
		end
	end
	////////////////////////////////////////////////////////////////
	// wire rules; the link clock comes from core flops, so core sampling is exact
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence high_half_s;
		link_clk [*2] ##1 !link_clk;
	endsequence
	sequence latch_s;
		link_le [*4] ##1 !link_le;
	endsequence
	AST_CLK_HIGH_HALF: assert property ($rose(link_clk) |-> high_half_s)
		else $error("link clock high phase has wrong length");
	AST_CLK_LOW_HALF: assert property ($fell(link_clk) |-> !link_clk [*2])
		else $error("link clock low phase too short");
	AST_DATA_HOLD: assert property (link_clk && $past(link_clk) |-> $stable(link_data))
		else $error("link data moved while clock high");
	AST_LE_ON_LOW: assert property ($rose(link_le) |-> !link_clk && edge_cnt_q == 5'h18)
		else $error("latch enable rose at wrong point");
	AST_LATCH_SPAN: assert property ($rose(link_le) |-> latch_s)
		else $error("latch enable width wrong");
	AST_LATCH_EDGE: assert property ($rose(link_clk) && link_le |-> edge_cnt_q == 5'h18)
		else $error("latching edge is not the 25th");
	AST_EDGE_LIMIT: assert property ($rose(link_clk) |-> edge_cnt_q <= 5'h18)
		else $error("too many link edges in a frame");
	AST_GAP_IDLE: assert property ($fell(link_le) |-> !link_clk [*6])
		else $error("link clock not idle after frame");
endmodule // rfcw_properties
`default_nettype wire

// File: testbench/rf_fastlock_config_words_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rf_fastlock_config_words_tb
	import rfcw_pkg::*;
;
	logic core_clk = 1'b0; // 50 MHz
	logic rst_n = 1'b0; // held for 6 cycles
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic pd_cycle = 1'b0, freq_write = 1'b0, frac_wide_sel = 1'b0;
	logic [11:0] den_lower = 12'hABC; // lower denominator bits
	logic [21:0] den;
	logic fl_act, pin_o, pin_oe, rf_tick, if_tick, rf_counter_reset, if_rst, rf_hiz, if_hiz;
	logic [4:0] mult;
	logic [2:0] cycle_slip_reduction_factor;
	logic [23:0] shift_q = 24'h000000, mon_word = 24'h000000; // word seen on the wire
	int miscompares = 0, checks_done = 0, rf_ticks = 0, if_ticks = 0;
	wire logic [14:0] obs; // device state packed as in the table
	assign obs = {fl_act, mult, cycle_slip_reduction_factor, pin_o, pin_oe, rf_counter_reset, if_rst, rf_hiz, if_hiz};
	// rows: word sent, then expected obs
	localparam logic [38:0] ROWS [10] = '{{24'h00081F, 15'h0202}, {24'h00082F, 15'h0201},
		{24'h00084F, 15'h020A}, {24'h00088F, 15'h0205}, {24'h00080F, 15'h0200},
		{24'h14000D, 15'h0200}, {24'h7C001D, 15'h6050}, {24'h80002D, 15'h0290},
		{24'hDC003D, 15'h0330}, {24'h00004D, 15'h0200}};

	always #10 core_clk = ~core_clk;
	rfcw_link_if lnk();
	rfcw_host rfcw_host_inst(.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(lnk.host));
	rfcw_device rfcw_device_inst(.core_clk(core_clk), .rst_n(rst_n), .link(lnk.device),
		.pd_cycle(pd_cycle), .freq_write(freq_write), .frac_wide_sel(frac_wide_sel),
		.den_lower(den_lower), .rf_frac_denominator(den), .rf_fastlock_active(fl_act),
		.rf_pump_mult(mult), .csr_log2(cycle_slip_reduction_factor), .rf_fastlock_pin_o(pin_o), .rf_fastlock_pin_oe(pin_oe),
		.rf_ld_tick(rf_tick), .if_ld_tick(if_tick), .rf_counters_reset(rf_counter_reset),
		.if_counters_reset(if_rst), .rf_pump_hiz(rf_hiz), .if_pump_hiz(if_hiz));
	rfcw_properties rfcw_properties_inst(.core_clk(core_clk), .rst_n(rst_n), .link_clk(lnk.link_clk),
		.link_data(lnk.link_data), .link_le(lnk.link_le));

	////////////////////////////////////////////////////////////////
	// wire monitor: shifts msb first, takes the word on the latch edge
	always @(posedge lnk.link_clk)
	begin
		if (lnk.link_le)
			mon_word <= shift_q;
		else
			shift_q <= {shift_q[22:0], lnk.link_data};
	end
	// lock-detect tick counters
	always @(posedge core_clk)
	begin
		if (rf_tick === 1'b1)
			rf_ticks++;
		if (if_tick === 1'b1)
			if_ticks++;
	end

	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
		end
		while (pready !== 1'b1); // only the watchdog ends a hung wait
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// poll busy, then compare the word the wire carried
	task automatic finish_word(input logic [23:0] w);
		logic [31:0] rd;
		logic err;
		do
		begin
			apb(1'b0, ADDR_STATUS, 32'h00000000, rd, err);
		end
		while (rd[STATUS_BUSY_BIT] !== 1'b0);
		chk("status read error", 32'h00000000, 32'(err));
		chk("link word", 32'(w), 32'(mon_word));
		repeat (8) @(posedge core_clk);
	endtask
	task automatic send(input logic [23:0] w);
		logic [31:0] rd;
		logic err;
		apb(1'b1, ADDR_WORD, 32'(w), rd, err);
		chk("word write error", 32'h00000000, 32'(err));
		finish_word(w);
	endtask
	task automatic pulse_pd(input int k);
		repeat (k)
		begin
			pd_cycle <= 1'b1;
			@(posedge core_clk);
			pd_cycle <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
	endtask
	task automatic pulse_fw();
		freq_write <= 1'b1;
		@(posedge core_clk);
		freq_write <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////
	// hang guard, well beyond the expected few thousand cycles
	initial
	begin
		#400000;
		miscompares++;
		$display("Error watchdog expected finish seen hang");
		print_verdict();
	end
	initial
	begin
		logic [31:0] rd;
		logic err;
		int r0, i0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		chk("power-up state", 32'h0000020F, 32'(obs));
		for (int i = 0; i < 10; i++)
		begin
			send(ROWS[i][38:15]);
			chk("row outputs", 32'(ROWS[i][14:0]), 32'(obs));
		end
		// denominator width select
		send(24'hA9400B);
		chk("narrow den", 32'h00000ABC, 32'(den));
		frac_wide_sel <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("wide den", 32'h002A5ABC, 32'(den));
		den_lower <= 12'hFFF;
		send(24'h00000B);
		chk("small wide den", 32'h00000FFF, 32'(den));
		// quarter-rate: 8 pulses give 2 rf ticks whatever the divider phase
		send(24'h00280F);
		r0 = rf_ticks;
		i0 = if_ticks;
		pulse_pd(8);
		chk("rf ld ticks", 32'h00000002, 32'(rf_ticks - r0));
		chk("if ld ticks", 32'h00000008, 32'(if_ticks - i0));
		// timed fast-lock, timeout 4 gives 8 cycles, restarted mid-way
		send(24'h0C004D);
		chk("timed idle", 32'h00000200, 32'(obs));
		pulse_fw();
		chk("timed run", 32'h00004810, 32'(obs));
		pulse_pd(5);
		pulse_fw();
		pulse_pd(7);
		chk("restarted run", 32'h00004810, 32'(obs));
		pulse_pd(1);
		chk("timed expiry", 32'h00000200, 32'(obs));
		// second word stalls behind the first frame
		apb(1'b1, ADDR_WORD, 32'h0000080F, rd, err);
		apb(1'b1, ADDR_WORD, 32'h0000000D, rd, err);
		chk("queued word", 32'h0000080F, 32'(mon_word));
		finish_word(24'h00000D);
		chk("timeout zero", 32'h00000200, 32'(obs));
		apb(1'b0, ADDR_LAST, 32'h00000000, rd, err);
		chk("last word", 32'h0000000D, rd);
		apb(1'b1, ADDR_STATUS, 32'h00000000, rd, err);
		chk("status write refused", 32'h00000001, 32'(err));
		apb(1'b0, 12'h00C, 32'h00000000, rd, err);
		chk("unmapped read data", 32'h00000000, rd);
		chk("unmapped read error", 32'h00000001, 32'(err));
		// a mid-run reset applies the counter reset again; the link must still work
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		chk("second reset state", 32'h0000020F, 32'(obs));
		send(24'h00080F);
		chk("after second reset", 32'h00000200, 32'(obs));
		print_verdict();
	end
endmodule // rf_fastlock_config_words_tb
`default_nettype wire
